// [logic/ucp_div.sv]
`timescale 1ns/1ps
module ucp_div #(
  parameter int W = ucp_pkg::DIV_W
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  ucp_div_if.slave  bus
);
  import ucp_pkg::*;

  logic         busy_r;
  logic [5:0]   cnt_r;
  logic [W:0]   rem_r;
  logic [W-1:0] quo_r;
  logic [W-1:0] den_r;
  logic         done_r;
  logic [W:0]   trial;

  assign trial        = {rem_r[W-1:0], quo_r[W-1]} - {1'b0, den_r};
  assign bus.quotient = quo_r;
  assign bus.done     = done_r;

  // Restoring divide, one quotient bit per cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      rem_r  <= '0;
      quo_r  <= '0;
      den_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && bus.start) begin
        if (bus.divisor == '0) begin
          quo_r  <= '0;
          done_r <= 1'b1;
        end else begin
          busy_r <= 1'b1;
          cnt_r  <= 6'(W);
          rem_r  <= '0;
          quo_r  <= bus.dividend;
          den_r  <= bus.divisor;
        end
      end else if (busy_r) begin
        if (!trial[W]) begin
          rem_r <= trial;
          quo_r <= {quo_r[W-2:0], 1'b1};
        end else begin
          rem_r <= {rem_r[W-1:0], quo_r[W-1]};
          quo_r <= {quo_r[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  div_finish_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (bus.start && !busy_r) |=> ##[0:33] done_r)
    else $error("divider did not finish in time");

endmodule // ucp_div

// [logic/ucp_div_if.sv]
`timescale 1ns/1ps
interface ucp_div_if #(parameter int W = 32);
  logic         start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic [W-1:0] quotient;
  logic         done;
  modport master (output start, output dividend, output divisor, input quotient, input done);
  modport slave  (input start, input dividend, input divisor, output quotient, output done);
endinterface // ucp_div_if

// [logic/ucp_pkg.sv]
package ucp_pkg;

  localparam int MAG_W    = 16;
  localparam int LVL_W    = 13;
  localparam int DLY_W    = 19;
  localparam int RAT_W    = 16;
  localparam int DIV_W    = 32;
  localparam int HOLD_W   = 24;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int EVAL_PERIOD_NS = 5000000;
  localparam int EVAL_CYCLES    = EVAL_PERIOD_NS / CLK_PERIOD_NS;

  localparam int UNB_SCALE = 300;
  localparam int PCT_FULL  = 100;
  localparam int HYST_PCT  = 97;

  localparam logic [LVL_W-1:0] ALARM_LVL_RST = 13'h0078;
  localparam logic [LVL_W-1:0] TRIP_LVL_RST  = 13'h0078;
  localparam int STEP_MS      = 5;
  localparam int DLY_DEF_MS   = 40;
  localparam logic [DLY_W-1:0] DLY_RST = DLY_W'(DLY_DEF_MS / STEP_MS);

  typedef enum logic [2:0] {
    UCP_S_IDLE  = 3'b000,
    UCP_S_LOAD  = 3'b001,
    UCP_S_UNB   = 3'b010,
    UCP_S_RAT   = 3'b011,
    UCP_S_WAITR = 3'b100,
    UCP_S_EVAL  = 3'b101
  } ucp_seq_t;

  typedef enum logic [2:0] {
    UCP_F_NORMAL   = 3'b000,
    UCP_F_BLOCKED  = 3'b001,
    UCP_F_ALARM_PU = 3'b010,
    UCP_F_ALARM    = 3'b011,
    UCP_F_TRIP_PU  = 3'b100,
    UCP_F_TRIP     = 3'b101
  } ucp_force_t;

  typedef enum logic [3:0] {
    UCP_C_NORMAL        = 4'h0,
    UCP_C_BLOCKED       = 4'h1,
    UCP_C_PU_ALARM      = 4'h2,
    UCP_C_PU_ALARM_TRIP = 4'h3,
    UCP_C_PU_TRIP       = 4'h4,
    UCP_C_ALARM_ON      = 4'h5,
    UCP_C_PICKUP_ON     = 4'h6,
    UCP_C_PU_WITH_ALARM = 4'h7,
    UCP_C_TRIP_ON       = 4'h8,
    UCP_C_ALARM_TRIP    = 4'h9,
    UCP_C_MULTI         = 4'hA
  } ucp_cond_t;

endpackage

// [logic/ucp_stage.sv]
`timescale 1ns/1ps
module ucp_stage #(
  parameter int EVAL_CYCLES = ucp_pkg::EVAL_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic [ucp_pkg::MAG_W-1:0] phase_a_fundamental_magnitude,
  input  wire logic [ucp_pkg::MAG_W-1:0] phase_b_fundamental_magnitude,
  input  wire logic [ucp_pkg::MAG_W-1:0] phase_c_fundamental_magnitude,
  input  wire logic                     block_in,
  input  wire logic                     setting_load,
  input  wire logic [ucp_pkg::LVL_W-1:0] alarm_level,
  input  wire logic [ucp_pkg::LVL_W-1:0] trip_level,
  input  wire logic [ucp_pkg::DLY_W-1:0] alarm_delay,
  input  wire logic [ucp_pkg::DLY_W-1:0] trip_delay,
  input  wire logic                     force_enable,
  input  wire ucp_pkg::ucp_force_t      force_status,
  output logic                          alarm_pickup_state,
  output logic                          alarm_out,
  output logic                          trip_pickup_state,
  output logic                          trip_out,
  output logic                          blocked_out,
  output ucp_pkg::ucp_cond_t            condition,
  output logic [ucp_pkg::RAT_W-1:0]     unbalance_ratio,
  output logic [ucp_pkg::RAT_W-1:0]     alarm_meas_ratio,
  output logic [ucp_pkg::RAT_W-1:0]     trip_meas_ratio,
  output logic [ucp_pkg::DLY_W-1:0]     alarm_remaining,
  output logic [ucp_pkg::DLY_W-1:0]     trip_remaining,
  output logic [ucp_pkg::DLY_W-1:0]     expected_alarm_time,
  output logic [ucp_pkg::DLY_W-1:0]     expected_trip_time,
  output logic                          eval_done
);
  import ucp_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  function automatic logic [RAT_W-1:0] sat_ratio(input logic [DIV_W-1:0] q);
    sat_ratio = (|q[DIV_W-1:RAT_W]) ? {RAT_W{1'b1}} : q[RAT_W-1:0];
  endfunction

  ucp_seq_t          seq_r;
  logic              tick;
  logic [MAG_W-1:0]  mag_r [3];
  logic              block_s_r;
  logic [MAG_W-1:0]  mx;
  logic [MAG_W-1:0]  mn;
  logic [DIV_W-1:0]  sum;
  logic [RAT_W-1:0]  unb_r;
  logic              unb_start_r;
  logic              rat_start_r;
  logic [1:0]        rdone_r;
  logic [1:0]        rdone;
  logic [DIV_W-1:0]  rquo [2];
  logic [RAT_W-1:0]  meas_r [2];
  logic [LVL_W-1:0]  lvl_r [2];
  logic [DLY_W-1:0]  dly_r [2];
  logic [1:0]        pu_r;
  logic [1:0]        out_r;
  logic [1:0]        want;
  logic [1:0]        pu_nxt;
  logic [DLY_W-1:0]  cnt_r [2];
  logic [DLY_W-1:0]  rem_r [2];
  logic              blocked_r;
  logic              eval;
  logic              f_ap;
  logic              f_ao;
  logic              f_tp;
  logic              f_to;
  logic              f_bl;
  ucp_cond_t         cond_nxt;

  assign eval = (seq_r == UCP_S_EVAL);

  ucp_tick #(.CYCLES(EVAL_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  // Setting group values, held until the next load
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_r[0] <= ALARM_LVL_RST;
      lvl_r[1] <= TRIP_LVL_RST;
      dly_r[0] <= DLY_RST;
      dly_r[1] <= DLY_RST;
    end else if (setting_load) begin
      lvl_r[0] <= alarm_level;
      lvl_r[1] <= trip_level;
      dly_r[0] <= alarm_delay;
      dly_r[1] <= trip_delay;
    end
  end

  // Input capture at the start of each evaluation
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mag_r[0]  <= '0;
      mag_r[1]  <= '0;
      mag_r[2]  <= '0;
      block_s_r <= 1'b0;
    end else if (tick && seq_r == UCP_S_IDLE) begin
      mag_r[0]  <= phase_a_fundamental_magnitude;
      mag_r[1]  <= phase_b_fundamental_magnitude;
      mag_r[2]  <= phase_c_fundamental_magnitude;
      block_s_r <= block_in;
    end
  end

  // Extremes and sum of the three phases
  always_comb begin
    mx = mag_r[0];
    mn = mag_r[0];
    for (int i = 1; i < 3; i++) begin
      if (mag_r[i] > mx) mx = mag_r[i];
      if (mag_r[i] < mn) mn = mag_r[i];
    end
    sum = DIV_W'(mag_r[0]) + DIV_W'(mag_r[1]) + DIV_W'(mag_r[2]);
  end

  ucp_div_if #(.W(DIV_W)) unb_if ();

  assign unb_if.start    = unb_start_r;
  assign unb_if.dividend = DIV_W'(UNB_SCALE) * DIV_W'(mx - mn);
  assign unb_if.divisor  = sum;

  ucp_div #(.W(DIV_W)) u_unb_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bus     (unb_if.slave)
  );

  // Evaluation sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seq_r       <= UCP_S_IDLE;
      unb_start_r <= 1'b0;
      rat_start_r <= 1'b0;
      unb_r       <= '0;
      eval_done   <= 1'b0;
    end else begin
      unb_start_r <= 1'b0;
      rat_start_r <= 1'b0;
      eval_done   <= 1'b0;
      case (seq_r)
        UCP_S_IDLE: begin
          if (tick) seq_r <= UCP_S_LOAD;
        end
        UCP_S_LOAD: begin
          unb_start_r <= 1'b1;
          seq_r       <= UCP_S_UNB;
        end
        UCP_S_UNB: begin
          if (unb_if.done) begin
            unb_r <= sat_ratio(unb_if.quotient);
            seq_r <= UCP_S_RAT;
          end
        end
        UCP_S_RAT: begin
          rat_start_r <= 1'b1;
          seq_r       <= UCP_S_WAITR;
        end
        UCP_S_WAITR: begin
          if (&rdone) seq_r <= UCP_S_EVAL;
        end
        UCP_S_EVAL: begin
          eval_done <= 1'b1;
          seq_r     <= UCP_S_IDLE;
        end
        default: seq_r <= UCP_S_IDLE;
      endcase
    end
  end

  // Per-channel ratio, pick-up and definite delay; 0 alarm, 1 trip
  for (genvar g = 0; g < 2; g++) begin : g_chan
    ucp_div_if #(.W(DIV_W)) rat_if ();

    assign rat_if.start    = rat_start_r;
    assign rat_if.dividend = DIV_W'(unb_r) * DIV_W'(PCT_FULL);
    assign rat_if.divisor  = DIV_W'(lvl_r[g]);
    assign rquo[g]         = rat_if.quotient;
    assign rdone[g]        = rdone_r[g] | rat_if.done;

    ucp_div #(.W(DIV_W)) u_rat_div (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .bus     (rat_if.slave)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        rdone_r[g] <= 1'b0;
        meas_r[g]  <= '0;
      end else if (seq_r == UCP_S_RAT) begin
        rdone_r[g] <= 1'b0;
      end else if (rat_if.done) begin
        rdone_r[g] <= 1'b1;
        meas_r[g]  <= sat_ratio(rquo[g]);
      end
    end

    assign want[g] = pu_r[g]
      ? (HOLD_W'(unb_r) * HOLD_W'(PCT_FULL) >= HOLD_W'(HYST_PCT) * HOLD_W'(lvl_r[g]))
      : (unb_r >= RAT_W'(lvl_r[g]));
    assign pu_nxt[g] = want[g] & ~block_s_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        pu_r[g]  <= 1'b0;
        out_r[g] <= 1'b0;
        cnt_r[g] <= '0;
        rem_r[g] <= '0;
      end else if (eval) begin
        pu_r[g] <= pu_nxt[g];
        if (!pu_nxt[g]) begin
          cnt_r[g] <= '0;
          out_r[g] <= 1'b0;
          rem_r[g] <= '0;
        end else if (cnt_r[g] < dly_r[g]) begin
          cnt_r[g] <= cnt_r[g] + 1'b1;
          out_r[g] <= (cnt_r[g] + 1'b1 >= dly_r[g]);
          rem_r[g] <= dly_r[g] - cnt_r[g] - 1'b1;
        end else begin
          out_r[g] <= 1'b1;
          rem_r[g] <= '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blocked_r <= 1'b0;
    end else if (eval) begin
      blocked_r <= block_s_r & (|want);
    end
  end

  // Status after the static force override
  always_comb begin
    f_ap = pu_r[0];
    f_ao = out_r[0];
    f_tp = pu_r[1];
    f_to = out_r[1];
    f_bl = blocked_r;
    if (force_enable) begin
      f_bl = (force_status == UCP_F_BLOCKED);
      f_ap = (force_status == UCP_F_ALARM_PU) || (force_status == UCP_F_ALARM);
      f_ao = (force_status == UCP_F_ALARM);
      f_tp = (force_status == UCP_F_TRIP_PU) || (force_status == UCP_F_TRIP);
      f_to = (force_status == UCP_F_TRIP);
    end
  end

  always_comb begin
    cond_nxt = UCP_C_NORMAL;
    if (f_bl && (f_ap || f_tp || f_ao || f_to)) cond_nxt = UCP_C_MULTI;
    else if (f_bl) cond_nxt = UCP_C_BLOCKED;
    else if (f_ao && f_to && f_ap && f_tp) cond_nxt = UCP_C_MULTI;
    else if (f_ao && f_to) cond_nxt = UCP_C_ALARM_TRIP;
    else if (f_to) cond_nxt = UCP_C_TRIP_ON;
    else if (f_ao && f_tp) cond_nxt = UCP_C_PU_WITH_ALARM;
    else if (f_ao) cond_nxt = UCP_C_ALARM_ON;
    else if (f_ap && f_tp) cond_nxt = UCP_C_PU_ALARM_TRIP;
    else if (f_ap) cond_nxt = UCP_C_PU_ALARM;
    else if (f_tp && force_enable) cond_nxt = UCP_C_PICKUP_ON;
    else if (f_tp) cond_nxt = UCP_C_PU_TRIP;
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alarm_pickup_state  <= 1'b0;
      alarm_out           <= 1'b0;
      trip_pickup_state   <= 1'b0;
      trip_out            <= 1'b0;
      blocked_out         <= 1'b0;
      condition           <= UCP_C_NORMAL;
      unbalance_ratio     <= '0;
      alarm_meas_ratio    <= '0;
      trip_meas_ratio     <= '0;
      alarm_remaining     <= '0;
      trip_remaining      <= '0;
      expected_alarm_time <= '0;
      expected_trip_time  <= '0;
    end else begin
      alarm_pickup_state  <= f_ap;
      alarm_out           <= f_ao;
      trip_pickup_state   <= f_tp;
      trip_out            <= f_to;
      blocked_out         <= f_bl;
      condition           <= cond_nxt;
      unbalance_ratio     <= unb_r;
      alarm_meas_ratio    <= meas_r[0];
      trip_meas_ratio     <= meas_r[1];
      alarm_remaining     <= rem_r[0];
      trip_remaining      <= rem_r[1];
      expected_alarm_time <= dly_r[0];
      expected_trip_time  <= dly_r[1];
    end
  end

  zero_mean_a: assert property (
    (seq_r == UCP_S_UNB && unb_if.done && sum == '0) |=> (unb_r == '0))
    else $error("zero mean current did not give zero unbalance");

  alarm_pick_a: assert property (
    (eval && !pu_r[0] && !block_s_r && unb_r >= RAT_W'(lvl_r[0])) |=> pu_r[0])
    else $error("alarm pick-up missed at level");

  hyst_hold_a: assert property (
    (eval && pu_r[1] && !block_s_r && unb_r < RAT_W'(lvl_r[1])
      && HOLD_W'(unb_r) * HOLD_W'(PCT_FULL) >= HOLD_W'(HYST_PCT) * HOLD_W'(lvl_r[1]))
      |=> pu_r[1])
    else $error("trip pick-up released inside hysteresis band");

  alarm_delay_a: assert property (
    $rose(out_r[0]) |-> (pu_r[0] && cnt_r[0] >= dly_r[0]))
    else $error("alarm asserted before delay expired");

  release_clear_a: assert property (
    (eval && !pu_nxt[1]) |=> (cnt_r[1] == '0 && !out_r[1]))
    else $error("trip timer not cleared on release");

  block_reset_a: assert property (
    (eval && block_s_r && (|want)) |=> (!pu_r[0] && !pu_r[1]) ##1 (blocked_out || force_enable))
    else $error("blocking did not reset pick-ups");

  force_trip_a: assert property (
    (force_enable && force_status == UCP_F_TRIP) |=> (trip_out && trip_pickup_state
      && !alarm_out && condition == UCP_C_TRIP_ON))
    else $error("forced trip not shown");

  trip_remain_a: assert property (
    (eval && pu_nxt[1] && cnt_r[1] < dly_r[1] && !setting_load)
      |=> ##1 (trip_remaining == dly_r[1] - cnt_r[1]))
    else $error("trip remaining time wrong");

  eval_latency_a: assert property (
    (tick && seq_r == UCP_S_IDLE) |=> ##[5:80] eval_done)
    else $error("evaluation did not complete in time");

endmodule // ucp_stage

// [logic/ucp_tick.sv]
`timescale 1ns/1ps
module ucp_tick #(
  parameter int CYCLES = ucp_pkg::EVAL_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      tick
);
  import ucp_pkg::*;

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;

  // Evaluation period counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  tick_single_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tick |=> !tick)
    else $error("evaluation tick lasted more than one cycle");

endmodule // ucp_tick

// [sim/ucp_bench.sv]
`timescale 1ns/1ps
module capacitor_unbalance_protection_bench;
  import ucp_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_blk = 1'b0;
  logic setting_load = 1'b0;
  logic force_enable = 1'b0;
  ucp_force_t force_status = UCP_F_NORMAL;
  logic [MAG_W-1:0] req_a = '0, req_b = '0, req_c = '0;
  logic [MAG_W-1:0] phase_a_fundamental_magnitude, phase_b_fundamental_magnitude;
  logic [MAG_W-1:0] phase_c_fundamental_magnitude;
  logic block_in;
  logic [LVL_W-1:0] alarm_level = 13'h0078, trip_level = 13'h0078;
  logic [DLY_W-1:0] alarm_delay = 19'h00008, trip_delay = 19'h00008;
  logic alarm_pickup_state, alarm_out, trip_pickup_state, trip_out, blocked_out, eval_done;
  ucp_cond_t condition;
  logic [RAT_W-1:0] unbalance_ratio, alarm_meas_ratio, trip_meas_ratio;
  logic [DLY_W-1:0] alarm_remaining, trip_remaining, expected_alarm_time, expected_trip_time;
  logic [4:0] st;
  logic [4:0] fexp [6];
  int n_errors = 0;
  int checks = 0;
  assign st = {alarm_pickup_state, alarm_out, trip_pickup_state, trip_out, blocked_out};

  ucp_meas_model ucp_meas_model_i (
    .ref_clk(ref_clk), .resetn(resetn), .req_a(req_a), .req_b(req_b), .req_c(req_c),
    .req_blk(req_blk), .mag_a(phase_a_fundamental_magnitude),
    .mag_b(phase_b_fundamental_magnitude), .mag_c(phase_c_fundamental_magnitude),
    .blk(block_in)
  );

  ucp_stage #(.EVAL_CYCLES(200)) ucp_stage_i (
    .ref_clk, .resetn, .phase_a_fundamental_magnitude, .phase_b_fundamental_magnitude,
    .phase_c_fundamental_magnitude, .block_in, .setting_load, .alarm_level, .trip_level,
    .alarm_delay, .trip_delay, .force_enable, .force_status, .alarm_pickup_state,
    .alarm_out, .trip_pickup_state, .trip_out, .blocked_out, .condition, .unbalance_ratio,
    .alarm_meas_ratio, .trip_meas_ratio, .alarm_remaining, .trip_remaining,
    .expected_alarm_time, .expected_trip_time, .eval_done
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Counts: %0d comparisons, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic load(input int al, input int tl, input int ad, input int td);
    @(posedge ref_clk);
    setting_load <= 1'b1;
    alarm_level <= LVL_W'(al);
    trip_level <= LVL_W'(tl);
    alarm_delay <= DLY_W'(ad);
    trip_delay <= DLY_W'(td);
    @(posedge ref_clk);
    setting_load <= 1'b0;
  endtask

  task automatic meas(input int a, input int b, input int c, input logic k);
    @(posedge ref_clk);
    req_a <= MAG_W'(a);
    req_b <= MAG_W'(b);
    req_c <= MAG_W'(c);
    req_blk <= k;
  endtask

  task automatic ev;
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if (eval_done === 1'b1) break;
    end
    if (i == 400) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
    end else begin
      @(negedge ref_clk);
    end
  endtask

  initial begin
    fexp = '{5'h00, 5'h01, 5'h10, 5'h18, 5'h04, 5'h06};
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(expected_alarm_time, 8);
    chk(expected_trip_time, 8);
    meas(160, 100, 40, 1'b0);
    ev();
    chk(unbalance_ratio, 120);
    chk(alarm_meas_ratio, 100);
    chk(trip_meas_ratio, 100);
    chk(st, 5'h14);
    chk(condition, UCP_C_PU_ALARM_TRIP);
    chk(alarm_remaining, 7);
    chk(trip_remaining, 7);
    $display("Test defaults done");
    meas(159, 99, 42, 1'b0);
    ev();
    chk(st, 5'h14);
    meas(158, 100, 42, 1'b0);
    ev();
    chk(st, 5'h00);
    chk(alarm_remaining, 0);
    meas(160, 99, 41, 1'b0);
    ev();
    chk(unbalance_ratio, 119);
    chk(st, 5'h00);
    $display("Test hysteresis done");
    load(120, 120, 2, 3);
    repeat (2) @(negedge ref_clk);
    chk(expected_alarm_time, 2);
    meas(160, 100, 40, 1'b0);
    ev();
    chk(alarm_remaining, 1);
    chk(trip_remaining, 2);
    ev();
    chk(st, 5'h1C);
    chk(trip_remaining, 1);
    ev();
    chk(st, 5'h1E);
    chk(condition, UCP_C_MULTI);
    meas(160, 100, 40, 1'b1);
    ev();
    chk(st, 5'h01);
    chk(condition, UCP_C_BLOCKED);
    chk(trip_remaining, 0);
    $display("Test delays and blocking done");
    load(100, 150, 8, 8);
    meas(160, 100, 40, 1'b0);
    ev();
    chk(alarm_meas_ratio, 120);
    chk(trip_meas_ratio, 80);
    chk(st, 5'h10);
    chk(condition, UCP_C_PU_ALARM);
    meas(0, 0, 0, 1'b0);
    ev();
    chk(unbalance_ratio, 0);
    chk(st, 5'h00);
    $display("Test levels and zero current done");
    @(posedge ref_clk);
    force_enable <= 1'b1;
    for (int f = 0; f < 6; f++) begin
      @(posedge ref_clk);
      force_status <= ucp_force_t'(f);
      repeat (2) @(negedge ref_clk);
      chk(st, fexp[f]);
    end
    load(120, 120, 8, 8);
    repeat (3) @(negedge ref_clk);
    chk(st, 5'h06);
    @(posedge ref_clk);
    force_enable <= 1'b0;
    ev();
    chk(st, 5'h00);
    $display("Test forcing done");
    report_and_stop();
  end
endmodule // capacitor_unbalance_protection_bench

// [sim/ucp_meas_model.sv]
`timescale 1ns/1ps
module ucp_meas_model
  import ucp_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic [ucp_pkg::MAG_W-1:0] req_a,
  input  wire logic [ucp_pkg::MAG_W-1:0] req_b,
  input  wire logic [ucp_pkg::MAG_W-1:0] req_c,
  input  wire logic                      req_blk,
  output logic      [ucp_pkg::MAG_W-1:0] mag_a,
  output logic      [ucp_pkg::MAG_W-1:0] mag_b,
  output logic      [ucp_pkg::MAG_W-1:0] mag_c,
  output logic                           blk
);
  // Magnitude channels, refreshed well inside each evaluation period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mag_a <= '0;
      mag_b <= '0;
      mag_c <= '0;
    end else begin
      mag_a <= req_a;
      mag_b <= req_b;
      mag_c <= req_c;
    end
  end

  // Blocking input, follows req_blk one clock cycle later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blk <= 1'b0;
    end else begin
      blk <= req_blk;
    end
  end
endmodule // ucp_meas_model
